// file: src/ftm_hyst.sv
// Switchpoint comparator with hysteresis below the switchpoint
`timescale 1ns/10ps
module ftm_hyst #(
  parameter int W = 11
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                en_i,
  input  wire logic                gate_i,
  input  wire logic signed [W-1:0] val_i,
  input  wire logic signed [W-1:0] sp_i,
  input  wire logic signed [W-1:0] hyst_i,
  output logic                     on_o
);

  // ==========================================================
  // Release threshold
  // One extra bit so a low switchpoint minus hysteresis never wraps
  logic signed [W:0] rel_thr;
  assign rel_thr = {sp_i[W-1], sp_i} - {hyst_i[W-1], hyst_i};

  // ==========================================================
  // Output state
  always_ff @(posedge clk_i) begin
    if (rst_i || !gate_i) begin
      on_o <= 1'b0;
    end else if (en_i) begin
      if (val_i >= sp_i) begin
        on_o <= 1'b1;
      end else if ($signed({val_i[W-1], val_i}) < rel_thr) begin
        on_o <= 1'b0;
      end
    end
  end

endmodule

// file: src/ftm_monitor.sv
// Flow and temperature threshold monitor with process word and bus
// ==========================================================
`timescale 1ns/10ps
module ftm_monitor #(
  parameter int unsigned HEAT_FIX_CYCLES = ftm_pkg::HEAT_FIX_CYCLES,
  parameter bit          HAS_FLOW_SWITCH = 1'b1,
  parameter int          ERR_N           = 4
) (
  input  wire logic                         MCLK_I,
  input  wire logic                         RST_I,
  input  wire logic [7:0]                   ADR_I,
  input  wire logic [31:0]                  DAT_I,
  output logic      [31:0]                  DAT_O,
  input  wire logic                         WE_I,
  input  wire logic [3:0]                   SEL_I,
  input  wire logic                         STB_I,
  input  wire logic                         CYC_I,
  output logic                              ACK_O,
  input  wire logic [ftm_pkg::FLOW_W-1:0]   FLOW_RAW_I,
  input  wire logic signed [ftm_pkg::TEMP_W-1:0] TEMP_I,
  input  wire logic                         SAMPLE_I,
  input  wire logic                         BTN_ENTER_I,
  input  wire logic                         BTN_SET_I,
  input  wire logic                         BTN_MODE_I,
  input  wire logic                         SENSOR_PRESENT_I,
  input  wire logic                         SENSOR_STABLE_I,
  input  wire logic [ERR_N-1:0]             ERR_I,
  input  wire logic                         LINK_ACTIVE_I,
  input  wire logic                         LINK_OPERATE_I,
  output logic                              OUT_FLOW_O,
  output logic                              OUT_TEMP_O,
  output logic                              OUT_FAULT_O,
  output logic                              LINK_LINE_O,
  output logic      [15:0]                  PD_WORD_O,
  output logic                              PD_VALID_O,
  output logic                              DISP_TEMP_O,
  output logic      [ftm_pkg::FLOW_W-1:0]   DISP_VALUE_O,
  output logic                              HEATING_O
);

  localparam int FW    = ftm_pkg::FLOW_W;
  localparam int TW    = ftm_pkg::TEMP_W;
  localparam int DW    = ftm_pkg::DIV_W;
  localparam int PIN_N = 7 + ERR_N;
  localparam int HEAT_W = $clog2(HEAT_FIX_CYCLES + 1);

  // ==========================================================
  // Pin synchronisers
  logic [PIN_N-1:0] pin_s1_r;
  logic [PIN_N-1:0] pin_s2_r;
  logic [PIN_N-1:0] pin_d_r;

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_d_r  <= '0;
    end else begin
      pin_s1_r <= {ERR_I, LINK_OPERATE_I, LINK_ACTIVE_I, SENSOR_STABLE_I,
                   SENSOR_PRESENT_I, BTN_MODE_I, BTN_SET_I, BTN_ENTER_I};
      pin_s2_r <= pin_s1_r;
      pin_d_r  <= pin_s2_r;
    end
  end

  logic btn_enter, btn_set, btn_mode, sens_present, sens_stable;
  logic link_active, link_operate, ext_err;
  logic enter_p, set_p, mode_p, present_p;
  assign btn_enter    = pin_s2_r[0];
  assign btn_set      = pin_s2_r[1];
  assign btn_mode     = pin_s2_r[2];
  assign sens_present = pin_s2_r[3];
  assign sens_stable  = pin_s2_r[4];
  assign link_active  = pin_s2_r[5];
  assign link_operate = pin_s2_r[6];
  assign ext_err      = |pin_s2_r[PIN_N-1:7];
  assign enter_p      = btn_enter & ~pin_d_r[0];
  assign set_p        = btn_set & ~pin_d_r[1];
  assign mode_p       = btn_mode & ~pin_d_r[2];
  assign present_p    = sens_present & ~pin_d_r[3];

  // ==========================================================
  // Heating phase
  logic              heating_r;
  logic [HEAT_W-1:0] heat_cnt_r;
  logic              fix_done;
  assign fix_done = heat_cnt_r == HEAT_W'(HEAT_FIX_CYCLES - 1);

  always_ff @(posedge MCLK_I) begin
    if (RST_I || present_p) begin
      heating_r  <= 1'b1;
      heat_cnt_r <= '0;
    end else if (heating_r) begin
      if (!fix_done) begin
        heat_cnt_r <= heat_cnt_r + HEAT_W'(1);
      end else if (sens_present && sens_stable) begin
        heating_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Parameters and guided learning
  logic [FW-1:0]        flow_lo_r, flow_hi_r, flow_sp_r, flow_hyst_r;
  logic signed [TW-1:0] temp_sp_r;
  logic [FW-1:0]        flow_field_r;
  ftm_pkg::ftm_teach_t  teach_r;
  logic                 keys_ok, param_ok, abort, wr_acc, factory;
  logic [31:0]          rd_word, wr_word;

  // Keys still show values while the link holds parameters
  assign keys_ok  = ~heating_r & ~link_active;
  assign param_ok = ~heating_r;
  assign abort    = btn_set & btn_mode & (set_p | mode_p);
  assign wr_acc   = CYC_I & STB_I & WE_I & ~ACK_O & param_ok;
  assign factory  = wr_acc && ADR_I == ftm_pkg::REG_CTRL && SEL_I[0] &&
                    DAT_I[ftm_pkg::CTRL_FACTORY];

  function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                           input logic [31:0] dat,
                                           input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = dat[8*i +: 8];
      end
    end
    return res;
  endfunction

  assign wr_word = wb_merge(rd_word, DAT_I, SEL_I);

  always_ff @(posedge MCLK_I) begin
    if (RST_I || factory) begin
      flow_lo_r   <= ftm_pkg::FLOW_LO_RST;
      flow_hi_r   <= ftm_pkg::FLOW_HI_RST;
      flow_sp_r   <= ftm_pkg::FLOW_SP_RST;
      flow_hyst_r <= ftm_pkg::FLOW_HYST_RST;
      temp_sp_r   <= ftm_pkg::TEMP_SP_RST;
      teach_r     <= ftm_pkg::T_IDLE;
    end else if (wr_acc) begin
      case (ADR_I)
        ftm_pkg::REG_FLOW_LO:   flow_lo_r   <= wr_word[FW-1:0];
        ftm_pkg::REG_FLOW_HI:   flow_hi_r   <= wr_word[FW-1:0];
        ftm_pkg::REG_FLOW_SP:   flow_sp_r   <= wr_word[FW-1:0];
        ftm_pkg::REG_FLOW_HYST: flow_hyst_r <= wr_word[FW-1:0];
        ftm_pkg::REG_TEMP_SP:   temp_sp_r   <= wr_word[TW-1:0];
        default: ;
      endcase
    end else if (!keys_ok || abort) begin
      teach_r <= ftm_pkg::T_IDLE;
    end else begin
      case (teach_r)
        ftm_pkg::T_IDLE: begin
          if (mode_p) begin
            teach_r <= ftm_pkg::T_LO;
          end else if (enter_p && HAS_FLOW_SWITCH) begin
            flow_sp_r <= flow_field_r;
          end
        end
        ftm_pkg::T_LO: begin
          if (enter_p) begin
            flow_lo_r <= FLOW_RAW_I;
          end
          if (enter_p || set_p || mode_p) begin
            teach_r <= ftm_pkg::T_HI;
          end
        end
        ftm_pkg::T_HI: begin
          if (enter_p) begin
            flow_hi_r <= FLOW_RAW_I;
          end
          if (enter_p || set_p || mode_p) begin
            teach_r <= HAS_FLOW_SWITCH ? ftm_pkg::T_FSP : ftm_pkg::T_TSP;
          end
        end
        ftm_pkg::T_FSP: begin
          if (enter_p) begin
            flow_sp_r <= flow_field_r;
          end
          if (enter_p || set_p || mode_p) begin
            teach_r <= ftm_pkg::T_TSP;
          end
        end
        ftm_pkg::T_TSP: begin
          if (set_p && temp_sp_r < ftm_pkg::TEMP_DISP_MAX) begin
            temp_sp_r <= temp_sp_r + TW'(1);
          end else if (mode_p && temp_sp_r > ftm_pkg::TEMP_DISP_MIN) begin
            temp_sp_r <= temp_sp_r - TW'(1);
          end else if (enter_p) begin
            teach_r <= ftm_pkg::T_IDLE;
          end
        end
        default: teach_r <= ftm_pkg::T_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Flow scaling over the display range
  // Serial divider: one result per sample, FW*2 cycles each
  logic [FW-1:0] span, flow_off;
  logic          span_bad;
  logic          div_busy_r, div_done_r;
  logic [4:0]    div_cnt_r;
  logic [DW-1:0] div_num_r, div_q_r;
  logic [FW:0]   div_rem_r, rem_sh;
  logic [FW-1:0] div_den_r;

  assign span     = flow_hi_r - flow_lo_r;
  assign span_bad = flow_hi_r <= flow_lo_r || span < ftm_pkg::FLOW_MIN_SPAN;
  assign flow_off = (FLOW_RAW_I <= flow_lo_r) ? '0 :
                    (FLOW_RAW_I >= flow_hi_r) ? span :
                    FLOW_RAW_I - flow_lo_r;
  assign rem_sh   = {div_rem_r[FW-1:0], div_num_r[DW-1]};

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      div_busy_r   <= 1'b0;
      div_done_r   <= 1'b0;
      div_cnt_r    <= '0;
      div_num_r    <= '0;
      div_q_r      <= '0;
      div_rem_r    <= '0;
      div_den_r    <= '0;
      flow_field_r <= '0;
    end else begin
      div_done_r <= 1'b0;
      if (!div_busy_r && SAMPLE_I) begin
        div_busy_r <= 1'b1;
        div_cnt_r  <= '0;
        div_num_r  <= DW'(flow_off) * DW'(ftm_pkg::FLOW_FULL);
        div_q_r    <= '0;
        div_rem_r  <= '0;
        div_den_r  <= span_bad ? FW'(1) : span;
      end else if (div_busy_r) begin
        div_num_r <= {div_num_r[DW-2:0], 1'b0};
        if (rem_sh >= {1'b0, div_den_r}) begin
          div_rem_r <= rem_sh - {1'b0, div_den_r};
          div_q_r   <= {div_q_r[DW-2:0], 1'b1};
        end else begin
          div_rem_r <= rem_sh;
          div_q_r   <= {div_q_r[DW-2:0], 1'b0};
        end
        div_cnt_r <= div_cnt_r + 5'h01;
        if (div_cnt_r == 5'(DW - 1)) begin
          div_busy_r <= 1'b0;
          div_done_r <= 1'b1;
        end
      end
      if (div_done_r) begin
        flow_field_r <= span_bad ? '0 :
                        (|div_q_r[DW-1:FW]) ? ftm_pkg::FLOW_FULL :
                        div_q_r[FW-1:0];
      end
    end
  end

  // ==========================================================
  // Switchpoint comparators
  logic                 flow_on, temp_on;
  logic signed [TW-1:0] temp_r;
  logic                 samp_d_r;

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      temp_r   <= '0;
      samp_d_r <= 1'b0;
    end else begin
      samp_d_r <= SAMPLE_I;
      if (SAMPLE_I) begin
        temp_r <= TEMP_I;
      end
    end
  end

  generate
    if (HAS_FLOW_SWITCH) begin : g_flow_sw
      // Compared on the scaled field, one cycle after it settles
      logic flow_upd_r;
      always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
          flow_upd_r <= 1'b0;
        end else begin
          flow_upd_r <= div_done_r;
        end
      end
      ftm_hyst #(.W(FW + 1)) u_flow_hyst (
        .clk_i  (MCLK_I),
        .rst_i  (RST_I),
        .en_i   (flow_upd_r),
        .gate_i (~heating_r),
        .val_i  ({1'b0, flow_field_r}),
        .sp_i   ({1'b0, flow_sp_r}),
        .hyst_i ({1'b0, flow_hyst_r}),
        .on_o   (flow_on)
      );
    end else begin : g_flow_cur
      assign flow_on = 1'b0;
    end
  endgenerate

  ftm_hyst #(.W(TW)) u_temp_hyst (
    .clk_i  (MCLK_I),
    .rst_i  (RST_I),
    .en_i   (samp_d_r),
    .gate_i (~heating_r),
    .val_i  (temp_r),
    .sp_i   (temp_sp_r),
    .hyst_i (ftm_pkg::TEMP_HYST),
    .on_o   (temp_on)
  );

  // ==========================================================
  // Faults and output drive
  logic err_any;
  assign err_any = ext_err | span_bad |
                   temp_r > ftm_pkg::TEMP_OPER_MAX |
                   temp_r < ftm_pkg::TEMP_OPER_MIN;

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      OUT_FLOW_O  <= 1'b0;
      OUT_TEMP_O  <= 1'b0;
      OUT_FAULT_O <= 1'b0;
      LINK_LINE_O <= 1'b0;
      HEATING_O   <= 1'b1;
    end else begin
      OUT_FLOW_O  <= flow_on;
      OUT_TEMP_O  <= temp_on;
      OUT_FAULT_O <= ~err_any;
      LINK_LINE_O <= ~link_active & flow_on;
      HEATING_O   <= heating_r;
    end
  end

  // ==========================================================
  // Process word and display
  logic signed [TW-1:0] temp_clip;
  assign temp_clip = (temp_r < ftm_pkg::TEMP_DISP_MIN) ?
                     ftm_pkg::TEMP_DISP_MIN :
                     (temp_r > ftm_pkg::TEMP_DISP_MAX) ?
                     ftm_pkg::TEMP_DISP_MAX : temp_r;

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      PD_WORD_O    <= '0;
      PD_VALID_O   <= 1'b0;
      DISP_TEMP_O  <= 1'b0;
      DISP_VALUE_O <= '0;
    end else begin
      PD_WORD_O <= '0;
      PD_WORD_O[ftm_pkg::PD_FLOW_MSB:ftm_pkg::PD_FLOW_LSB] <=
        flow_field_r;
      PD_WORD_O[ftm_pkg::PD_FAULT_BIT] <= ~err_any;
      PD_WORD_O[ftm_pkg::PD_TEMP_BIT]  <= temp_on;
      PD_WORD_O[ftm_pkg::PD_FLOWO_BIT] <= flow_on;
      // Data only once the link has finished its parameter exchange
      PD_VALID_O  <= link_active & link_operate;
      DISP_TEMP_O <= btn_set & ~heating_r &
                     teach_r == ftm_pkg::T_IDLE;
      if (btn_set && !heating_r && teach_r == ftm_pkg::T_IDLE) begin
        DISP_VALUE_O <= FW'(temp_clip - ftm_pkg::TEMP_DISP_MIN);
      end else begin
        DISP_VALUE_O <= flow_field_r;
      end
    end
  end

  // ==========================================================
  // Wishbone slave
  always_comb begin
    rd_word = '0;
    case (ADR_I)
      ftm_pkg::REG_FLOW_LO:   rd_word[FW-1:0] = flow_lo_r;
      ftm_pkg::REG_FLOW_HI:   rd_word[FW-1:0] = flow_hi_r;
      ftm_pkg::REG_FLOW_SP:   rd_word[FW-1:0] = flow_sp_r;
      ftm_pkg::REG_FLOW_HYST: rd_word[FW-1:0] = flow_hyst_r;
      ftm_pkg::REG_TEMP_SP:   rd_word[TW-1:0] = temp_sp_r;
      ftm_pkg::REG_STATUS: begin
        rd_word[ftm_pkg::ST_FLOW]      = OUT_FLOW_O;
        rd_word[ftm_pkg::ST_TEMP]      = OUT_TEMP_O;
        rd_word[ftm_pkg::ST_FAULT]     = OUT_FAULT_O;
        rd_word[ftm_pkg::ST_HEAT]      = heating_r;
        rd_word[ftm_pkg::ST_LINK]      = link_active;
        rd_word[ftm_pkg::ST_OPERATE]   = link_operate;
        rd_word[ftm_pkg::ST_DISP_TEMP] = DISP_TEMP_O;
        rd_word[ftm_pkg::ST_TEACH]     = teach_r != ftm_pkg::T_IDLE;
      end
      ftm_pkg::REG_PDATA: rd_word[15:0] = PD_WORD_O;
      ftm_pkg::REG_DISP:  rd_word[FW-1:0] = DISP_VALUE_O;
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      ACK_O <= 1'b0;
      DAT_O <= '0;
    end else begin
      ACK_O <= CYC_I & STB_I & ~ACK_O;
      DAT_O <= (CYC_I && STB_I && !WE_I && !ACK_O) ? rd_word : '0;
    end
  end

endmodule

// file: src/ftm_pkg.sv
// Constants shared by the flow and temperature threshold monitor
package ftm_pkg;

  // ==========================================================
  // Widths
  localparam int FLOW_W = 10;
  localparam int TEMP_W = 9;
  localparam int DIV_W  = 2 * FLOW_W;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_FLOW_LO   = 8'h04;
  localparam logic [7:0] REG_FLOW_HI   = 8'h08;
  localparam logic [7:0] REG_FLOW_SP   = 8'h0C;
  localparam logic [7:0] REG_FLOW_HYST = 8'h10;
  localparam logic [7:0] REG_TEMP_SP   = 8'h14;
  localparam logic [7:0] REG_STATUS    = 8'h18;
  localparam logic [7:0] REG_PDATA     = 8'h1C;
  localparam logic [7:0] REG_DISP      = 8'h20;

  // ==========================================================
  // Field positions
  localparam int CTRL_FACTORY  = 0;
  localparam int ST_FLOW       = 0;
  localparam int ST_TEMP       = 1;
  localparam int ST_FAULT      = 2;
  localparam int ST_HEAT       = 3;
  localparam int ST_LINK       = 4;
  localparam int ST_OPERATE    = 5;
  localparam int ST_DISP_TEMP  = 6;
  localparam int ST_TEACH      = 7;
  localparam int PD_FLOW_MSB   = 15;
  localparam int PD_FLOW_LSB   = 6;
  localparam int PD_FAULT_BIT  = 2;
  localparam int PD_TEMP_BIT   = 1;
  localparam int PD_FLOWO_BIT  = 0;

  // ==========================================================
  // Reset values and limits
  localparam logic [FLOW_W-1:0] FLOW_FULL     = 10'h3FF;
  localparam int                FLOW_SP_PCT   = 70;
  localparam logic [FLOW_W-1:0] FLOW_SP_RST   =
    FLOW_W'((1023 * FLOW_SP_PCT) / 100);
  localparam logic [FLOW_W-1:0] FLOW_LO_RST   = 10'h000;
  localparam logic [FLOW_W-1:0] FLOW_HI_RST   = 10'h3FF;
  localparam logic [FLOW_W-1:0] FLOW_HYST_RST = 10'h010;
  localparam logic [FLOW_W-1:0] FLOW_MIN_SPAN = 10'h020;
  localparam logic signed [TEMP_W-1:0] TEMP_SP_RST   = 9'h046;
  localparam logic signed [TEMP_W-1:0] TEMP_HYST     = 9'h002;
  localparam logic signed [TEMP_W-1:0] TEMP_DISP_MIN = 9'h1EA;
  localparam logic signed [TEMP_W-1:0] TEMP_DISP_MAX = 9'h0B3;
  localparam logic signed [TEMP_W-1:0] TEMP_OPER_MIN = 9'h1D6;
  localparam logic signed [TEMP_W-1:0] TEMP_OPER_MAX = 9'h0B8;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ      = 40000000;
  localparam int unsigned HEAT_FIX_S  = 10;
  localparam int unsigned HEAT_FIX_CYCLES = HEAT_FIX_S * CLK_HZ;

  // ==========================================================
  // Guided learning steps
  typedef enum logic [2:0] {
    T_IDLE, T_LO, T_HI, T_FSP, T_TSP
  } ftm_teach_t;

endpackage

// file: tb/ftm_link_master.sv
// Behavioural link master port: wake-up, parameters, cyclic phase
`timescale 1ns/10ps
module ftm_link_master (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic req_i,
  input  wire logic slow_i,
  output logic      active_o,
  output logic      operate_o
);
  logic [7:0] cnt_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || !req_i) begin
      cnt_r     <= 8'h00;
      active_o  <= 1'b0;
      operate_o <= 1'b0;
    end else begin
      cnt_r     <= (cnt_r == 8'hFF) ? cnt_r : cnt_r + 8'h01;
      // Talks only once the wake-up got its answer
      active_o  <= cnt_r >= (slow_i ? 8'h20 : 8'h04);
      // Parameter exchange first, cyclic data after
      operate_o <= cnt_r >= (slow_i ? 8'h60 : 8'h0C);
    end
  end
endmodule

// file: tb/ftm_monitor_checker.sv
// Port assertions for the flow and temperature threshold monitor
`timescale 1ns/10ps
module ftm_monitor_checker #(
  parameter int ERR_N = 4
) (
  input wire logic             MCLK_I,
  input wire logic             RST_I,
  input wire logic             CYC_I,
  input wire logic             STB_I,
  input wire logic             ACK_O,
  input wire logic [31:0]      DAT_O,
  input wire logic [ERR_N-1:0] ERR_I,
  input wire logic             BTN_SET_I,
  input wire logic             LINK_ACTIVE_I,
  input wire logic             LINK_OPERATE_I,
  input wire logic             LINK_LINE_O,
  input wire logic             OUT_FLOW_O,
  input wire logic             OUT_TEMP_O,
  input wire logic             OUT_FAULT_O,
  input wire logic [15:0]      PD_WORD_O,
  input wire logic             PD_VALID_O,
  input wire logic             DISP_TEMP_O,
  input wire logic             HEATING_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RST_I);
  // ==========================================================
  // Bus handshake
  sequence s_req;
    CYC_I && STB_I && !ACK_O;
  endsequence
  sequence s_ack_pulse;
    ACK_O ##1 !ACK_O;
  endsequence
  property p_ack;
    s_req |=> s_ack_pulse;
  endproperty
  a_ack: assert property (p_ack) else $error("request not acked once");
  property p_dat_idle;
    !ACK_O |-> DAT_O == 32'h0000_0000;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data off ack");
  // ==========================================================
  // Outputs and process word; repeats cover the input synchronisers
  property p_pd_unused;
    PD_WORD_O[5:3] == 3'h0;
  endproperty
  a_pd_unused: assert property (p_pd_unused) else $error("pd spare set");
  property p_heat_off;
    HEATING_O ##1 HEATING_O |-> !OUT_FLOW_O && !OUT_TEMP_O;
  endproperty
  a_heat_off: assert property (p_heat_off) else $error("out in heat");
  property p_line_plain;
    (!LINK_ACTIVE_I && $stable(OUT_FLOW_O))[*6] |-> LINK_LINE_O == OUT_FLOW_O;
  endproperty
  a_line_plain: assert property (p_line_plain) else $error("line");
  property p_line_quiet;
    LINK_ACTIVE_I[*6] |-> !LINK_LINE_O;
  endproperty
  a_line_quiet: assert property (p_line_quiet) else $error("line busy");
  property p_pd_valid;
    (LINK_ACTIVE_I && LINK_OPERATE_I)[*6] |-> PD_VALID_O;
  endproperty
  a_pd_valid: assert property (p_pd_valid) else $error("pd not valid");
  property p_fault;
    (|ERR_I)[*6] |-> !OUT_FAULT_O;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not shown");
  property p_disp_flow;
    (!BTN_SET_I)[*6] |-> !DISP_TEMP_O;
  endproperty
  a_disp_flow: assert property (p_disp_flow) else $error("temp shown");
endmodule

bind ftm_monitor ftm_monitor_checker #(.ERR_N(ERR_N)) u_chk (
  .MCLK_I(MCLK_I), .RST_I(RST_I), .CYC_I(CYC_I), .STB_I(STB_I),
  .ACK_O(ACK_O), .DAT_O(DAT_O), .ERR_I(ERR_I), .BTN_SET_I(BTN_SET_I),
  .LINK_ACTIVE_I(LINK_ACTIVE_I), .LINK_OPERATE_I(LINK_OPERATE_I),
  .LINK_LINE_O(LINK_LINE_O), .OUT_FLOW_O(OUT_FLOW_O),
  .OUT_TEMP_O(OUT_TEMP_O), .OUT_FAULT_O(OUT_FAULT_O),
  .PD_WORD_O(PD_WORD_O), .PD_VALID_O(PD_VALID_O),
  .DISP_TEMP_O(DISP_TEMP_O), .HEATING_O(HEATING_O));

// file: tb/ftm_monitor_test.sv
// Self-checking bench for the flow and temperature threshold monitor
`timescale 1ns/10ps
module ftm_monitor_test;
  typedef struct {
    bit rd; logic [7:0] a; logic [9:0] f; logic [8:0] t; logic [31:0] e;
  } ftm_row_t;
  logic clk = 1'b0, rst = 1'b1, we = 1'b0, stb = 1'b0, smp = 1'b0;
  logic b_ent = 1'b0, b_set = 1'b0, b_mode = 1'b0, stable = 1'b0;
  logic pres = 1'b1, lreq = 1'b0, lslow = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat_w = 32'h0, dat_r, rd;
  logic [9:0] flow = 10'h000, dval;
  logic signed [8:0] temp = 9'h000;
  logic [3:0] err = 4'h0;
  logic ack, l_act, l_op, o_flow, o_temp, o_fault, line, pdv, dtemp, heat;
  logic [15:0] pd;
  logic cur_flow;
  logic [2:0] keys [6] = '{3'h4, 3'h1, 3'h2, 3'h2, 3'h2, 3'h1};
  int err_total = 0, checks = 0, cyc = 0, t0;
  ftm_row_t rows [10];

  ftm_monitor #(.HEAT_FIX_CYCLES(16)) dut (
    .MCLK_I(clk), .RST_I(rst), .ADR_I(adr), .DAT_I(dat_w), .DAT_O(dat_r),
    .WE_I(we), .SEL_I(4'hF), .STB_I(stb), .CYC_I(stb), .ACK_O(ack),
    .FLOW_RAW_I(flow), .TEMP_I(temp), .SAMPLE_I(smp), .BTN_ENTER_I(b_ent),
    .BTN_SET_I(b_set), .BTN_MODE_I(b_mode), .SENSOR_PRESENT_I(pres),
    .SENSOR_STABLE_I(stable), .ERR_I(err), .LINK_ACTIVE_I(l_act),
    .LINK_OPERATE_I(l_op), .OUT_FLOW_O(o_flow), .OUT_TEMP_O(o_temp),
    .OUT_FAULT_O(o_fault), .LINK_LINE_O(line), .PD_WORD_O(pd),
    .PD_VALID_O(pdv), .DISP_TEMP_O(dtemp), .DISP_VALUE_O(dval),
    .HEATING_O(heat));
  ftm_link_master u_master (.clk_i(clk), .rst_i(rst), .req_i(lreq),
    .slow_i(lslow), .active_o(l_act), .operate_o(l_op));
  // Current-output variant: shares the pins, bus left idle
  ftm_monitor #(.HEAT_FIX_CYCLES(16), .HAS_FLOW_SWITCH(1'b0)) dut_cur (
    .MCLK_I(clk), .RST_I(rst), .ADR_I(adr), .DAT_I(dat_w), .DAT_O(),
    .WE_I(we), .SEL_I(4'hF), .STB_I(1'b0), .CYC_I(1'b0), .ACK_O(),
    .FLOW_RAW_I(flow), .TEMP_I(temp), .SAMPLE_I(smp), .BTN_ENTER_I(b_ent),
    .BTN_SET_I(b_set), .BTN_MODE_I(b_mode), .SENSOR_PRESENT_I(pres),
    .SENSOR_STABLE_I(stable), .ERR_I(err), .LINK_ACTIVE_I(l_act),
    .LINK_OPERATE_I(l_op), .OUT_FLOW_O(cur_flow), .OUT_TEMP_O(),
    .OUT_FAULT_O(), .LINK_LINE_O(), .PD_WORD_O(), .PD_VALID_O(),
    .DISP_TEMP_O(), .DISP_VALUE_O(), .HEATING_O());

  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      err_total++;
      end_of_test();
    end
  end
  // ==========================================================
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wb(input bit w, input logic [7:0] a, input logic [31:0] d);
    adr <= a;
    dat_w <= d;
    we <= w;
    stb <= 1'b1;
    do tick(1); while (ack !== 1'b1);
    rd = dat_r;
    stb <= 1'b0;
    tick(1);
  endtask
  task automatic samp(input logic [9:0] f, input logic [8:0] t);
    flow <= f;
    temp <= t;
    smp <= 1'b1;
    tick(1);
    smp <= 1'b0;
    tick(30);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function automatic logic [31:0] pw(logic [9:0] f, logic t, logic o);
    return {16'h0000, f, 3'h0, 1'b1, t, o};
  endfunction
  // ==========================================================
  // Sequence
  initial begin
    rows = '{'{1, ftm_pkg::REG_FLOW_LO, 0, 0, 32'h000},
             '{1, ftm_pkg::REG_FLOW_HI, 0, 0, 32'h3FF},
             '{1, ftm_pkg::REG_FLOW_SP, 0, 0, 32'(ftm_pkg::FLOW_SP_RST)},
             '{1, ftm_pkg::REG_FLOW_HYST, 0, 0, 32'h010},
             '{1, ftm_pkg::REG_TEMP_SP, 0, 0, 32'h046},
             '{1, 8'h24, 0, 0, 32'h000},
             '{0, 8'h00, 10'h2CB, 9'h045, pw(10'h2CB, 1'b0, 1'b0)},
             '{0, 8'h00, 10'h2CC, 9'h046, pw(10'h2CC, 1'b1, 1'b1)},
             '{0, 8'h00, 10'h2BC, 9'h044, pw(10'h2BC, 1'b1, 1'b1)},
             '{0, 8'h00, 10'h2BB, 9'h043, pw(10'h2BB, 1'b0, 1'b0)}};
    tick(10);
    rst <= 1'b0;
    t0 = cyc;
    wb(1, ftm_pkg::REG_FLOW_SP, 32'h100); // Refused while heating
    tick(30);
    chk(32'(heat), 32'h1, "heat wait");
    stable <= 1'b1;
    while (heat !== 1'b0 && cyc - t0 < 200) tick(1);
    chk(32'(heat), 32'h0, "heat end");
    $display("test heating done");
    foreach (rows[i]) begin
      if (rows[i].rd) begin
        wb(0, rows[i].a, 32'h0);
        chk(rd, rows[i].e, "reg");
      end else begin
        samp(rows[i].f, rows[i].t);
        chk({16'h0, pd}, rows[i].e, "pd");
        chk({o_temp, o_flow}, rows[i].e[1:0], "out");
      end
    end
    $display("test rows done");
    samp(10'h100, 9'h014);
    b_ent <= 1'b1;
    tick(6);
    b_ent <= 1'b0;
    tick(6);
    wb(0, ftm_pkg::REG_FLOW_SP, 32'h0);
    chk(rd, 32'h100, "quick sp");
    wb(0, ftm_pkg::REG_FLOW_HI, 32'h0);
    chk(rd, 32'h3FF, "quick range");
    lreq <= 1'b1;
    while (pdv !== 1'b1 && cyc - t0 < 2000) tick(1);
    chk({pdv, line}, 32'h2, "link");
    samp(10'h200, 9'h014);
    b_ent <= 1'b1;
    b_set <= 1'b1;
    tick(6);
    chk({dtemp, dval}, {1'b1, 10'h02A}, "disp");
    b_ent <= 1'b0;
    b_set <= 1'b0;
    tick(6);
    chk(32'(dtemp), 32'h0, "disp off");
    wb(0, ftm_pkg::REG_FLOW_SP, 32'h0);
    chk(rd, 32'h100, "key lock");
    lreq <= 1'b0;
    tick(8);
    chk({o_flow, line}, 32'h3, "plain line");
    chk(32'(cur_flow), 32'h0, "current variant");
    $display("test link done");
    wb(1, ftm_pkg::REG_CTRL, 32'h1);
    wb(0, ftm_pkg::REG_FLOW_SP, 32'h0);
    chk(rd, 32'(ftm_pkg::FLOW_SP_RST), "factory");
    wb(1, ftm_pkg::REG_FLOW_HI, 32'h1FF);
    samp(10'h0FF, 9'h014);
    chk(32'(dval), 32'h1FE, "scaled");
    err <= 4'h4;
    tick(8);
    chk({o_fault, pd[2]}, 32'h0, "fault");
    err <= 4'h0;
    tick(8);
    chk(32'(o_fault), 32'h1, "healthy");
    $display("test factory and fault done");
    // Guided cycle: teach lo, skip hi and flow point, raise temp by one
    foreach (keys[k]) begin
      {b_mode, b_set, b_ent} <= keys[k];
      tick(5);
      {b_mode, b_set, b_ent} <= 3'h0;
      tick(5);
    end
    wb(0, ftm_pkg::REG_FLOW_LO, 32'h0);
    chk(rd, 32'h0FF, "teach lo");
    wb(0, ftm_pkg::REG_TEMP_SP, 32'h0);
    chk(rd, 32'h047, "teach temp");
    $display("test teach done");
    end_of_test();
  end
endmodule
